/* rtl/uart_irq_pkg.sv */
// shared constants and carrier types for the uart interrupt-enable block
package uart_irq_pkg;
  // wishbone byte addresses of the registers (one aligned word each)
  localparam logic [5:0] ADDR_IER = 6'h00;
  localparam logic [5:0] ADDR_ISR = 6'h04;
  localparam logic [5:0] ADDR_LSR = 6'h08;
  localparam logic [5:0] ADDR_FCR = 6'h0C;
  localparam logic [5:0] ADDR_EFR = 6'h10;
  localparam logic [5:0] ADDR_EXTENDED_MODE_REG = 6'h14;
  localparam logic [5:0] ADDR_MSR = 6'h18;
  localparam logic [5:0] ADDR_RESUME_CHAR_ONE = 6'h1C;
  localparam logic [5:0] ADDR_RESUME_CHAR_TWO = 6'h20;
  localparam logic [5:0] ADDR_STOP_CHAR_ONE = 6'h24;
  localparam logic [5:0] ADDR_STOP_CHAR_TWO = 6'h28;
  localparam logic [5:0] ADDR_FEATURE_CONTROL = 6'h2C;
  localparam logic [5:0] ADDR_TRG = 6'h30;
  localparam logic [5:0] ADDR_DEVICE_REVISION = 6'h34;
  localparam logic [5:0] ADDR_DEVICE_IDENTIFIER = 6'h38;
  localparam logic [5:0] ADDR_THR = 6'h3C;
  // field positions
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int EFR_ENH = 4;
  localparam int EXTENDED_MODE_REG_IMM = 6;
  localparam int FCR_EN = 0;
  // reset values and enhanced ier bit mask
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ENH_MASK = 8'hF0;
  // identity values, arbitrary
  localparam logic [7:0] REV_ID = 8'h01;
  localparam logic [7:0] DEV_ID = 8'h5A;
  // isr codes
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_LS = 6'h06;
  localparam logic [5:0] ISR_RX = 6'h04;
  localparam logic [5:0] ISR_TX = 6'h02;
  localparam logic [5:0] ISR_MS = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;

  // channel-side status inputs
  typedef struct packed {
    logic [6:0] rx_level;
    logic [6:0] rx_trigger;
    logic rx_push;
    logic rx_push_err;
    logic rx_overrun;
    logic head_parity;
    logic head_framing;
    logic head_break;
    logic rx_pop_err;
    logic any_err;
    logic thr_empty;
    logic tx_all_empty;
    logic tx_below_trig;
    logic modem_delta;
    logic xoff_seen;
    logic rts_rise;
    logic cts_rise;
  } chan_stat_t;

  // block-side control outputs
  typedef struct packed {
    logic [7:0] fifo_control_reg;
    logic thr_write;
    logic [7:0] thr_data;
    logic rhr_read;
    logic sleep_en;
  } chan_ctl_t;
endpackage

/* rtl/uart_irq_regs.sv */
// interrupt enable, status and enhanced registers of one uart channel
// Contract
// [R01] enable register gates rx, tx, line and modem sources into status register
// [R02] fifo mode rx interrupt raises at trigger level, drops below it
// [R03] rx status code shows at trigger, clears with interrupt below it
// [R04] data ready flag sets on push, clears when fifo empty
// [R05] fifos on and enable bits 0-3 clear gives polled mode
// [R06] rx and tx status flags are independent for polling
// [R07] lsr bit1 overrun; bits 2-4 error type of head byte
// [R08] lsr bit5 holding empty; bit6 fifo and shift register empty
// [R09] lsr bit7 set when any fifo character has an error
// [R10] enable bit0 gives rx interrupt on held char or trigger level
// [R11] enable bit1 gives tx interrupt on empty or below tx trigger
// [R12] enabling tx while already empty interrupts at once
// [R13] enable bit2 gives line interrupt when lsr bits 1-4 set
// [R14] overrun interrupts on receipt; errors by default on readout
// [R15] extended mode bit6 makes errors interrupt on receipt
// [R16] enable bit3 gates modem interrupt, default off
// [R17] enable bit4 is sleep enable, needs enhanced bit
// [R18] enable bit5 gates xoff interrupt, needs enhanced bit
// [R19] enable bit6 interrupts on rts rising, needs enhanced bit
// [R20] line interrupt cleared by reading line status register
// [R21] tx interrupt cleared by isr read or holding register write
// [R22] enable bit7 interrupts on cts rising, needs enhanced bit
// [R23] interrupt output high while any enabled source pending
// [R24] enable bits 4-7 ignore writes and read zero without enhanced bit
`timescale 1ns/1ps
module uart_irq_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // channel side
  input wire uart_irq_pkg::chan_stat_t stat_i,
  output uart_irq_pkg::chan_ctl_t ctl_o,
  // interrupt line
  output logic irq_o
);
  logic [7:0] ier_q, efr_q, extended_mode_reg_q, fcr_q, feature_control_q, trg_q, msr_q;
  logic [7:0] resume_char_one_q, resume_char_two_q, stop_char_one_q, stop_char_two_q;
  logic ls_pend_q, tx_pend_q, xoff_pend_q, flow_pend_q, ms_pend_q;
  logic any_err_q;
  logic tx_prev_q, tx_rise;
  logic req, wr, rd, wr_ok, unmapped;
  logic enh, fifo_on, rx_lvl_hit, tx_cond, ls_err_now;
  logic [7:0] line_status_reg, interrupt_status_reg, rdata;
  logic [5:0] code;

  // one-cycle ack; request taken only while ack is low
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i && !unmapped;
  assign wr_ok = wr && wb_sel_i[0];
  assign rd = req && !wb_we_i && !unmapped;
  assign enh = efr_q[uart_irq_pkg::EFR_ENH];
  assign fifo_on = fcr_q[uart_irq_pkg::FCR_EN];

  function automatic logic hit(input logic [5:0] a);
    hit = wr_ok && (wb_adr_i == a);
  endfunction

  function automatic logic rhit(input logic [5:0] a);
    rhit = rd && (wb_adr_i == a);
  endfunction

  // rx trigger: fifo level at or above trigger in fifo mode, else any held char
  assign rx_lvl_hit = fifo_on ? (stat_i.rx_level >= stat_i.rx_trigger) // R02 R10
                              : (stat_i.rx_level != 7'h00);
  assign tx_cond = fifo_on ? stat_i.tx_below_trig : stat_i.thr_empty; // R11
  assign tx_rise = tx_cond && !tx_prev_q;
  assign ls_err_now = stat_i.rx_overrun || (extended_mode_reg_q[uart_irq_pkg::EXTENDED_MODE_REG_IMM] && stat_i.rx_push_err); // R14 R15

  // line status register; rx bits and tx bits kept apart for polling
  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[0] = stat_i.rx_level != 7'h00; // R04 R06
    line_status_reg[1] = ls_pend_q && stat_i.rx_overrun; // R07
    line_status_reg[2] = stat_i.head_parity; // R07
    line_status_reg[3] = stat_i.head_framing;
    line_status_reg[4] = stat_i.head_break;
    line_status_reg[5] = stat_i.thr_empty; // R08 R06
    line_status_reg[6] = stat_i.tx_all_empty; // R08
    line_status_reg[7] = fifo_on && any_err_q; // R09
  end

  // priority encode pending enabled sources
  always_comb begin
    code = uart_irq_pkg::ISR_NONE;
    if (ier_q[uart_irq_pkg::IER_LS] && ls_pend_q) begin // R13
      code = uart_irq_pkg::ISR_LS;
    end else if (ier_q[uart_irq_pkg::IER_RX] && rx_lvl_hit) begin // R01 R03
      code = uart_irq_pkg::ISR_RX;
    end else if (ier_q[uart_irq_pkg::IER_TX] && tx_pend_q) begin
      code = uart_irq_pkg::ISR_TX;
    end else if (ier_q[uart_irq_pkg::IER_MS] && ms_pend_q) begin // R16
      code = uart_irq_pkg::ISR_MS;
    end else if (ier_q[5] && xoff_pend_q) begin // R18
      code = uart_irq_pkg::ISR_XOFF;
    end else if ((ier_q[6] || ier_q[7]) && flow_pend_q) begin // R19 R22
      code = uart_irq_pkg::ISR_FLOW;
    end
    interrupt_status_reg = {fifo_on, fifo_on, code};
  end

  assign unmapped = (wb_adr_i[1:0] != 2'b00) || (wb_adr_i > uart_irq_pkg::ADDR_THR);

  // read mux
  always_comb begin
    rdata = 8'h00;
    if (wb_adr_i == uart_irq_pkg::ADDR_IER) begin
      rdata = ier_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_ISR) begin
      rdata = interrupt_status_reg;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_LSR) begin
      rdata = line_status_reg;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_EFR) begin
      rdata = efr_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_MSR) begin
      rdata = msr_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_RESUME_CHAR_ONE) begin
      rdata = resume_char_one_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_RESUME_CHAR_TWO) begin
      rdata = resume_char_two_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_STOP_CHAR_ONE) begin
      rdata = stop_char_one_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_STOP_CHAR_TWO) begin
      rdata = stop_char_two_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_FEATURE_CONTROL) begin
      rdata = feature_control_q;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_TRG) begin
      rdata = {1'b0, stat_i.rx_level};
    end else if (wb_adr_i == uart_irq_pkg::ADDR_DEVICE_REVISION) begin
      rdata = uart_irq_pkg::REV_ID;
    end else if (wb_adr_i == uart_irq_pkg::ADDR_DEVICE_IDENTIFIER) begin
      rdata = uart_irq_pkg::DEV_ID;
    end
  end

  // bus acknowledge, one cycle after the request is taken
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !unmapped;
    end
  end

  // bus error for unmapped addresses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req && unmapped;
    end
  end

  // read data, valid with ack and zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= (req && !wb_we_i && !unmapped) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  // interrupt enable register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ier_q <= uart_irq_pkg::IER_RST; // R10 R11 R16
    end else if (hit(uart_irq_pkg::ADDR_IER)) begin
      ier_q <= enh ? wb_dat_i[7:0] : {4'h0, wb_dat_i[3:0]}; // R24 R17
    end else if (!enh) begin
      ier_q <= ier_q & ~uart_irq_pkg::ENH_MASK; // R24
    end
  end

  // enhanced feature register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      efr_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_EFR)) begin
      efr_q <= wb_dat_i[7:0];
    end
  end

  // extended mode register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      extended_mode_reg_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_EXTENDED_MODE_REG)) begin
      extended_mode_reg_q <= wb_dat_i[7:0];
    end
  end

  // fifo control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fcr_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_FCR)) begin
      fcr_q <= wb_dat_i[7:0];
    end
  end

  // feature control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      feature_control_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_FEATURE_CONTROL)) begin
      feature_control_q <= wb_dat_i[7:0];
    end
  end

  // transmit trigger level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trg_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_TRG)) begin
      trg_q <= wb_dat_i[7:0];
    end
  end

  // first resume character
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resume_char_one_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_RESUME_CHAR_ONE)) begin
      resume_char_one_q <= wb_dat_i[7:0];
    end
  end

  // second resume character
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resume_char_two_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_RESUME_CHAR_TWO)) begin
      resume_char_two_q <= wb_dat_i[7:0];
    end
  end

  // first stop character
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stop_char_one_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_STOP_CHAR_ONE)) begin
      stop_char_one_q <= wb_dat_i[7:0];
    end
  end

  // second stop character
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stop_char_two_q <= uart_irq_pkg::REG_RST;
    end else if (hit(uart_irq_pkg::ADDR_STOP_CHAR_TWO)) begin
      stop_char_two_q <= wb_dat_i[7:0];
    end
  end

  // line status interrupt: set on overrun/immediate error or head error readout
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ls_pend_q <= 1'b0;
    end else if (ls_err_now || stat_i.rx_pop_err) begin // R14 R15
      ls_pend_q <= 1'b1;
    end else if (rhit(uart_irq_pkg::ADDR_LSR)) begin
      ls_pend_q <= 1'b0; // R20
    end
  end

  // error-in-fifo flag, registered each cycle for lsr bit 7
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      any_err_q <= 1'b0;
    end else begin
      any_err_q <= stat_i.any_err || stat_i.rx_push_err; // R09
    end
  end

  // tx ready interrupt: set on enable while empty or on a new empty, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_pend_q <= 1'b0;
    end else if (hit(uart_irq_pkg::ADDR_IER) && wb_dat_i[uart_irq_pkg::IER_TX] && tx_cond) begin
      tx_pend_q <= 1'b1; // R12
    end else if (tx_rise && ier_q[uart_irq_pkg::IER_TX]) begin
      tx_pend_q <= 1'b1; // R11
    end else if (hit(uart_irq_pkg::ADDR_THR) || (rhit(uart_irq_pkg::ADDR_ISR) && code == uart_irq_pkg::ISR_TX)) begin
      tx_pend_q <= 1'b0; // R21
    end
  end

  // last tx condition; starts high so the empty holding register after reset is no new edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_prev_q <= 1'b1;
    end else begin
      tx_prev_q <= tx_cond;
    end
  end

  // modem pending flag, cleared by modem status read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ms_pend_q <= 1'b0;
    end else if (stat_i.modem_delta) begin
      ms_pend_q <= 1'b1; // R16
    end else if (rhit(uart_irq_pkg::ADDR_MSR)) begin
      ms_pend_q <= 1'b0;
    end
  end

  // stop character pending flag, cleared by status read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xoff_pend_q <= 1'b0;
    end else if (stat_i.xoff_seen) begin
      xoff_pend_q <= 1'b1; // R18
    end else if (rhit(uart_irq_pkg::ADDR_ISR)) begin
      xoff_pend_q <= 1'b0;
    end
  end

  // rts/cts rising pending flag, cleared by modem status read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flow_pend_q <= 1'b0;
    end else if ((ier_q[6] && stat_i.rts_rise) || (ier_q[7] && stat_i.cts_rise)) begin
      flow_pend_q <= 1'b1; // R19 R22
    end else if (rhit(uart_irq_pkg::ADDR_MSR)) begin
      flow_pend_q <= 1'b0;
    end
  end

  // modem status read-back: pending rts/cts and modem flags
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      msr_q <= uart_irq_pkg::REG_RST;
    end else begin
      msr_q <= {6'h00, flow_pend_q, ms_pend_q};
    end
  end

  // control outputs to the channel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_o <= '0;
    end else begin
      ctl_o.fifo_control_reg <= fcr_q;
      ctl_o.thr_write <= hit(uart_irq_pkg::ADDR_THR);
      ctl_o.thr_data <= wb_dat_i[7:0];
      ctl_o.rhr_read <= rhit(uart_irq_pkg::ADDR_TRG);
      ctl_o.sleep_en <= enh && ier_q[4]; // R17
    end
  end

  // interrupt line
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (code != uart_irq_pkg::ISR_NONE); // R23 R05
    end
  end
endmodule

/* verif/testbench.sv */
// self-checking bench for the uart interrupt register block
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [3:0] bsel = 4'hF;
  logic [31:0] rdat;
  logic ack, err, irq, e;
  logic [7:0] q;
  uart_irq_pkg::chan_stat_t stat;
  uart_irq_pkg::chan_stat_t ev [3];
  uart_irq_pkg::chan_ctl_t ctl;
  int mismatches = 0;
  int check_count = 0;
  uart_irq_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .stat_i(stat), .ctl_o(ctl), .irq_o(irq));
  uart_chan_model ch (.sys_clk(sys_clk), .ctl_i(ctl), .stat_o(stat));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; holds until ack or err
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, bsel};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = rdat[7:0];
    e = err;
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x);
    bus(a, 1'b0, 8'h00);
    chk(q, x);
  endtask
  task automatic irq_is(input logic x);
    repeat (3) @(posedge sys_clk);
    chk({7'h0, irq}, {7'h0, x});
  endtask
  task automatic pulse(input uart_irq_pkg::chan_stat_t m);
    @(posedge sys_clk);
    ch.p <= m;
    @(posedge sys_clk);
    ch.p <= '0;
  endtask
  initial begin
    #40000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    ev[0] = '{xoff_seen: 1'b1, default: '0};
    ev[1] = '{rts_rise: 1'b1, default: '0};
    ev[2] = '{cts_rise: 1'b1, default: '0};
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    irq_is(1'b0);
    rd(6'h00, 8'h00);
    rd(6'h04, 8'h01);
    rd(6'h38, uart_irq_pkg::DEV_ID);
    bsel = 4'h0;
    bus(6'h00, 1'b1, 8'h0F);
    bsel = 4'hF;
    rd(6'h00, 8'h00);
    bus(6'h02, 1'b0, 8'h00);
    chk({7'h0, e}, 8'h01);
    bus(6'h00, 1'b1, 8'hF0);
    rd(6'h00, 8'h00);
    bus(6'h10, 1'b1, 8'h10);
    bus(6'h00, 1'b1, 8'hF0);
    rd(6'h00, 8'hF0);
    chk({7'h0, ctl.sleep_en}, 8'h01);
    bus(6'h10, 1'b1, 8'h00);
    rd(6'h00, 8'h00);
    // transmit ready
    bus(6'h00, 1'b1, 8'h02);
    irq_is(1'b1);
    rd(6'h04, 8'h02);
    irq_is(1'b0);
    bus(6'h3C, 1'b1, 8'hA5);
    chk(ctl.thr_data, 8'hA5);
    repeat (12) @(posedge sys_clk);
    irq_is(1'b1);
    bus(6'h3C, 1'b1, 8'h5A);
    irq_is(1'b0);
    bus(6'h00, 1'b1, 8'h00);
    bus(6'h0C, 1'b1, 8'h01);
    repeat (12) @(posedge sys_clk);
    {ch.s.rx_level, ch.s.rx_trigger} <= {7'h03, 7'h04};
    {ch.s.head_parity, ch.s.head_break, ch.s.any_err} <= 3'b111;
    rd(6'h08, 8'hF5);
    irq_is(1'b0);
    rd(6'h04, 8'hC1);
    {ch.s.head_parity, ch.s.head_break, ch.s.any_err} <= 3'b000;
    // receive trigger
    bus(6'h00, 1'b1, 8'h01);
    irq_is(1'b0);
    ch.s.rx_level <= 7'h04;
    irq_is(1'b1);
    rd(6'h04, 8'hC4);
    ch.s.rx_level <= 7'h03;
    irq_is(1'b0);
    rd(6'h04, 8'hC1);
    // line status
    bus(6'h00, 1'b1, 8'h04);
    ch.s.rx_overrun <= 1'b1;
    irq_is(1'b1);
    rd(6'h04, 8'hC6);
    rd(6'h08, 8'h63);
    ch.s.rx_overrun <= 1'b0;
    rd(6'h08, 8'h61);
    irq_is(1'b0);
    pulse('{rx_push_err: 1'b1, default: '0});
    irq_is(1'b0);
    pulse('{rx_pop_err: 1'b1, default: '0});
    irq_is(1'b1);
    rd(6'h08, 8'h61);
    bus(6'h14, 1'b1, 8'h40);
    pulse('{rx_push_err: 1'b1, default: '0});
    irq_is(1'b1);
    rd(6'h08, 8'h61);
    irq_is(1'b0);
    // modem and enhanced sources
    bus(6'h00, 1'b1, 8'h08);
    pulse('{modem_delta: 1'b1, default: '0});
    irq_is(1'b1);
    rd(6'h04, 8'hC0);
    bus(6'h18, 1'b0, 8'h00);
    irq_is(1'b0);
    bus(6'h10, 1'b1, 8'h10);
    for (int i = 0; i < 3; i++) begin
      bus(6'h00, 1'b1, 8'h20 << i);
      pulse(ev[i]);
      irq_is(1'b1);
      rd(6'h04, i == 0 ? 8'hD0 : 8'hE0);
      bus(6'h18, 1'b0, 8'h00);
      irq_is(1'b0);
    end
    tally_and_finish();
  end
endmodule

/* verif/uart_chan_model.sv */
// behavioural channel: status levels and pulses, busy transmitter
`timescale 1ns/1ps
module uart_chan_model (
  // clock
  input wire logic sys_clk,
  // block side
  input wire uart_irq_pkg::chan_ctl_t ctl_i,
  output uart_irq_pkg::chan_stat_t stat_o
);
  uart_irq_pkg::chan_stat_t s = '0;
  uart_irq_pkg::chan_stat_t p = '0;
  logic [3:0] busy_q = 4'h0;
  // a written character keeps the transmitter busy for eight cycles
  always @(posedge sys_clk) begin
    if (ctl_i.thr_write) begin
      busy_q <= 4'h8;
    end else if (busy_q != 4'h0) begin
      busy_q <= busy_q - 4'h1;
    end
  end
  always_comb begin
    stat_o = s | p;
    stat_o.thr_empty = (busy_q == 4'h0);
    stat_o.tx_all_empty = (busy_q == 4'h0);
  end
endmodule

/* verif/uart_irq_checker.sv */
// port assertions for the uart interrupt register block
`timescale 1ns/1ps
module uart_irq_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // channel and interrupt
  input wire uart_irq_pkg::chan_stat_t stat_i,
  input wire uart_irq_pkg::chan_ctl_t ctl_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  logic wr0;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr0 = take && wb_we_i && wb_sel_i[0];
  a_bus_answer: assert property (take |=> wb_ack_o != wb_err_o) else $error("no single answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_err_unmapped: assert property (take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o) else $error("bad address acked");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_thr_strobe: assert property (wr0 && wb_adr_i == uart_irq_pkg::ADDR_THR |=>
    ctl_o.thr_write && ctl_o.thr_data == $past(wb_dat_i[7:0])) else $error("holding write lost");
  a_read_quiet: assert property (take && !wb_we_i |=> !ctl_o.thr_write) else $error("read made a write");
  a_fcr_cause: assert property ($changed(ctl_o.fifo_control_reg) |-> $past(wr0 && wb_adr_i == uart_irq_pkg::ADDR_FCR, 2))
    else $error("fifo control changed alone");
  a_sleep_cause: assert property ($rose(ctl_o.sleep_en) |-> $past(wr0 && wb_dat_i[4] && wb_adr_i == 6'h00, 2))
    else $error("sleep enable rose alone");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq_o && !wb_ack_o) else $error("busy after reset");
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (wb_err_o);
  c_thr: cover property (ctl_o.thr_write);
endmodule
bind uart_irq_regs uart_irq_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .stat_i(stat_i), .ctl_o(ctl_o),
  .irq_o(irq_o));
